// >>> inc/fdc_pkg.sv
// shared constants and types for the floppy command sequencer
package fdc_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STEP_UNIT_NS = 1000000; // time per step rate code
  localparam int STEP_PULSE_NS = 1000;   // step pulse width, least
  localparam int STEP_CODES = 16;        // rate code 0 is slowest
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_UNIT_DEF = (STEP_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RECAL_STEPS = 8'h50; // give-up limit

  // ------------------------------------------------------------
  // bus map, byte addresses
  // ------------------------------------------------------------
  localparam logic [3:0] ADR_DATA = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;

  // ------------------------------------------------------------
  // opcodes, parameter and result counts
  // ------------------------------------------------------------
  localparam logic [4:0] OP_WRITE = 5'h05;
  localparam logic [4:0] OP_WRDEL = 5'h09;
  localparam logic [5:0] OP_FORMAT = 6'h0D;
  localparam logic [7:0] OP_RECAL = 8'h07;
  localparam logic [7:0] OP_SENSE = 8'h08;
  localparam logic [7:0] OP_SPEC = 8'h03;
  localparam logic [7:0] OP_SEEK = 8'h0F;
  localparam logic [3:0] NP_RW = 4'h8;
  localparam logic [3:0] NP_FMT = 4'h5;
  localparam logic [3:0] NP_RECAL = 4'h1;
  localparam logic [3:0] NP_SEEK = 4'h2;
  localparam logic [3:0] NP_SPEC = 4'h2;
  localparam logic [2:0] NR_RW = 3'h7;
  localparam logic [2:0] NR_SENSE = 3'h2;
  localparam logic [2:0] NR_ONE = 3'h1;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam logic [7:0] ST0_SEEK_END = 8'h20;

  // parameter byte slots (0 is the drive/head byte)
  localparam int P_DRV = 0;
  localparam int P_CYL = 1;
  localparam int P_HEAD = 2;
  localparam int P_REC = 3;
  localparam int P_SIZE = 4;
  localparam int P_EOT = 5;
  localparam int P_FSC = 2;
  localparam logic [21:0] SEC_BASE = 22'h000080; // size code 0 bytes
  localparam int ID_SHIFT = 2; // four id bytes per formatted sector

  // ------------------------------------------------------------
  // byte layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic multi_side_continue;
    logic double_density_select;
    logic [5:0] code;
  } op_t;
  typedef struct packed {
    logic [4:0] zero;
    logic head_side_select;
    logic drive_select_high;
    logic drive_select_low;
  } dh_t;
  typedef struct packed {
    logic [3:0] step_interval;
    logic [3:0] head_unload_time;
  } spec1_t;
  typedef struct packed {
    logic [6:0] head_load_time;
    logic no_dma_flag;
  } spec2_t;

  // ------------------------------------------------------------
  // modes and carriers
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_CMD  = 5'b00010,
    PH_EXEC = 5'b00100,
    PH_SEEK = 5'b01000,
    PH_RES  = 5'b10000
  } phase_t;
  typedef enum logic [2:0] {
    CM_INVALID, CM_WRITE, CM_WRDEL, CM_FORMAT,
    CM_RECAL, CM_SENSE, CM_SPEC, CM_SEEK
  } cmd_t;
  typedef struct packed {
    logic go;
    logic recal;
    logic [1:0] drive;
    logic [7:0] start;
    logic [7:0] target;
    logic [3:0] interval;
  } seek_req_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic [7:0] cyl;
  } seek_rsp_t;
  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0] fifo_level;
    logic seek_busy;
    logic irq;
    logic res_ready;
    phase_t phase;
  } status_t;

endpackage : fdc_pkg

// >>> verilog/byte_fifo.sv
// parameterised valid/ready fifo for the write data path
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage words
    logic [AW-1:0] wr;                // write pointer
    logic [AW-1:0] rd;                // read pointer
    logic [LW-1:0] cnt;               // words held
  } fifo_t;
  fifo_t q;
  fifo_t n;
  logic push;
  logic pop;

  // pointer wrap works for any depth, not only powers of two
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  assign in_ready_o = q.cnt != LW'(DEPTH);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rd];
  assign level_o = q.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wr] = in_data_i;
      n.wr = nxt(q.wr);
    end
    if (pop) begin
      n.rd = nxt(q.rd);
    end
    n.cnt = q.cnt + LW'(push) - LW'(pop);
  end

  // storage is cleared too so reads never show stale x
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule : byte_fifo

// >>> verilog/step_engine.sv
// head stepper that walks a drive to a cylinder or to track 0
`timescale 1ns/1ps
module step_engine import fdc_pkg::*; #(
  parameter int STEP_UNIT_CYC = STEP_UNIT_DEF,
  parameter logic [7:0] RECAL_MAX = RECAL_STEPS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request and answer
  input wire seek_req_t req_i,
  output seek_rsp_t rsp_o,
  // drive pins
  input wire logic track0_i,
  output logic step_o,
  output logic dir_o
);
  typedef enum logic [3:0] {
    SP_IDLE   = 4'b0001,
    SP_DECIDE = 4'b0010,
    SP_PULSE  = 4'b0100,
    SP_WAIT   = 4'b1000
  } sp_t;
  typedef struct packed {
    logic [2:0] sync;    // track 0 synchroniser chain
    logic trk;           // filtered track 0 level
    sp_t ph;             // walk phase
    logic [7:0] cyl;     // head position
    logic [7:0] tgt;     // wanted cylinder
    logic recal;         // walking to track 0
    logic [7:0] steps;   // pulses given
    logic [31:0] cnt;    // phase timer
    logic [3:0] interval;
    logic step;
    logic dir;
    logic done;
  } eng_t;
  eng_t q;
  eng_t n;
  logic arrived;

  // recalibrate gives up after a fixed count so a dead drive ends
  assign arrived = q.recal ? (q.trk || q.steps == RECAL_MAX)
                           : (q.cyl == q.tgt);
  assign step_o = q.step;
  assign dir_o = q.dir;
  assign rsp_o = '{busy: q.ph != SP_IDLE, done: q.done, cyl: q.cyl};

  // ------------------------------------------------------------
  // walk sequencer
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.done = 1'b0;
    n.sync = {q.sync[1:0], track0_i};
    // level taken once second and third stage agree
    if (q.sync[2] == q.sync[1]) begin
      n.trk = q.sync[2];
    end
    unique case (q.ph)
      SP_IDLE: begin
        if (req_i.go) begin
          n.cyl = req_i.start;
          n.tgt = req_i.target;
          n.recal = req_i.recal;
          n.interval = req_i.interval;
          n.steps = '0;
          n.ph = SP_DECIDE;
        end
      end
      SP_DECIDE: begin
        if (arrived) begin
          n.done = 1'b1;
          if (q.recal) begin
            n.cyl = '0;
          end
          n.ph = SP_IDLE;
        end else begin
          n.dir = q.recal ? 1'b0 : (q.tgt > q.cyl);
          n.step = 1'b1;
          n.cnt = 32'(STEP_PULSE_CYC - 1);
          n.ph = SP_PULSE;
        end
      end
      SP_PULSE: begin
        if (q.cnt == '0) begin
          n.step = 1'b0;
          n.cyl = q.dir ? q.cyl + 1'b1 : q.cyl - 1'b1;
          n.steps = q.steps + 1'b1;
          n.cnt = 32'((STEP_CODES - int'(q.interval)) * STEP_UNIT_CYC - 1);
          n.ph = SP_WAIT;
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      SP_WAIT: begin
        if (q.cnt == '0) begin
          n.ph = SP_DECIDE;
        end else begin
          n.cnt = q.cnt - 1'b1;
        end
      end
      default: n.ph = SP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ph <= SP_IDLE;
    end else begin
      q <= n;
    end
  end

endmodule : step_engine

// >>> verilog/fdc_cmd.sv
// floppy command decoder and sequencer behind a wishbone port
`timescale 1ns/1ps
module fdc_cmd import fdc_pkg::*; #(
  parameter int STEP_UNIT_CYC = STEP_UNIT_DEF,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // drive control
  output logic step_o,
  output logic dir_o,
  input wire logic track0_i,
  output logic [1:0] drive_sel_o,
  output logic head_sel_o,
  output logic int_o,
  // write data stream to the drive
  output logic [7:0] disk_data_o,
  output logic disk_valid_o,
  input wire logic disk_ready_i,
  output logic disk_deleted_o,
  output logic disk_format_o
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    phase_t phase;          // command phase
    cmd_t cmd;              // command in progress
    logic [7:0][7:0] prm;   // parameter bytes
    logic [3:0] pidx;       // next parameter slot
    logic [3:0] plen;       // parameters expected
    logic [6:0][7:0] res;   // result bytes, slot 0 read first
    logic [2:0] ridx;       // next result byte
    logic [2:0] rlen;       // result bytes to give
    logic [21:0] feed;      // bytes software still owes
    logic [21:0] left;      // bytes the drive still takes
    logic ack;
    logic [31:0] dat;
    logic irq;              // seek or recalibrate ended
    logic [1:0] irq_drv;    // drive that ended
    logic [3:0][7:0] pcyl;  // present cylinder per drive
    spec1_t spec1;
    spec2_t spec2;
    seek_req_t sreq;
    logic [7:0] odat;       // byte offered to the drive
    logic ovld;
    logic [1:0] dsel;
    logic head;
    logic wdel;
    logic fmt;
  } state_t;
  state_t q;
  state_t n;

  logic wb_req;
  logic wr_data;
  logic rd_data;
  logic feeding;
  logic stall;
  logic push;
  logic pop;
  logic take;
  logic fifo_rdy;
  logic fifo_vld;
  logic [7:0] fifo_dat;
  logic [LW-1:0] fifo_lvl;
  seek_rsp_t srsp;

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  function automatic cmd_t decode(input logic [7:0] b);
    op_t o;
    o = op_t'(b);
    decode = CM_INVALID;
    if (!o.code[5] && o.code[4:0] == OP_WRITE) begin
      decode = CM_WRITE;
    end else if (!o.code[5] && o.code[4:0] == OP_WRDEL) begin
      decode = CM_WRDEL;
    end else if (!o.multi_side_continue && o.code == OP_FORMAT) begin
      decode = CM_FORMAT;
    end else if (b == OP_RECAL) begin
      decode = CM_RECAL;
    end else if (b == OP_SENSE) begin
      decode = CM_SENSE;
    end else if (b == OP_SPEC) begin
      decode = CM_SPEC;
    end else if (b == OP_SEEK) begin
      decode = CM_SEEK;
    end
  endfunction : decode

  function automatic logic [3:0] plen_of(input cmd_t c);
    unique case (c)
      CM_WRITE, CM_WRDEL: plen_of = NP_RW;
      CM_FORMAT: plen_of = NP_FMT;
      CM_RECAL: plen_of = NP_RECAL;
      CM_SEEK: plen_of = NP_SEEK;
      CM_SPEC: plen_of = NP_SPEC;
      default: plen_of = 4'h0;
    endcase
  endfunction : plen_of

  // ------------------------------------------------------------
  // bus strobes and data path handshakes
  // ------------------------------------------------------------
  assign wb_req = cyc_i && stb_i && !q.ack;
  assign wr_data = wb_req && we_i && sel_i[0] && adr_i == ADR_DATA;
  assign rd_data = wb_req && !we_i && adr_i == ADR_DATA;
  assign feeding = q.phase == PH_EXEC && q.feed != '0;
  // a full fifo holds off the bus ack, so software is throttled
  assign stall = wr_data && feeding && !fifo_rdy;
  assign push = wr_data && feeding && fifo_rdy;
  assign take = q.ovld && disk_ready_i;
  assign pop = fifo_vld && (!q.ovld || disk_ready_i);

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .in_data_i(dat_i[7:0]),
    .out_valid_o(fifo_vld),
    .out_ready_i(pop),
    .out_data_o(fifo_dat),
    .level_o(fifo_lvl)
  );

  step_engine #(.STEP_UNIT_CYC(STEP_UNIT_CYC)) u_step (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(q.sreq),
    .rsp_o(srsp),
    .track0_i(track0_i),
    .step_o(step_o),
    .dir_o(dir_o)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic launch;
    dh_t dh;
    logic [8:0] secs;
    logic [21:0] bytes;
    launch = 1'b0;
    dh = '0;
    secs = '0;
    bytes = '0;
    n = q;
    n.ack = 1'b0;
    n.sreq.go = 1'b0;
    // output register toward the drive
    if (take) begin
      n.ovld = 1'b0;
      n.left = q.left - 1'b1;
    end
    if (pop) begin
      n.odat = fifo_dat;
      n.ovld = 1'b1;
    end
    if (push) begin
      n.feed = q.feed - 1'b1;
    end
    // bus access, answered one cycle after the strobe unless a full fifo stalls it
    if (wb_req && !stall) begin
      n.ack = 1'b1;
      n.dat = '0;
      if (!we_i && adr_i == ADR_STAT) begin
        n.dat = status_t'{rsvd: '0, fifo_level: 8'(fifo_lvl),
                          seek_busy: srsp.busy, irq: q.irq,
                          res_ready: q.phase == PH_RES,
                          phase: q.phase};
      end
      if (wr_data) begin
        unique case (q.phase)
          PH_IDLE: begin
            n.cmd = decode(dat_i[7:0]);
            n.plen = plen_of(n.cmd);
            n.pidx = '0;
            n.phase = PH_CMD;
            launch = n.plen == 4'h0;
          end
          PH_CMD: begin
            n.prm[q.pidx] = dat_i[7:0];
            n.pidx = q.pidx + 1'b1;
            launch = q.pidx == q.plen - 4'h1;
          end
          default: ; // exec bytes go to the fifo, others are dropped
        endcase
      end
      if (rd_data && q.phase == PH_RES) begin
        n.dat = {24'h000000, q.res[q.ridx]};
        n.ridx = q.ridx + 1'b1;
        if (q.ridx == q.rlen - 3'h1) begin
          n.phase = PH_IDLE;
        end
      end
    end
    // last command byte taken: enter the exec, seek, result or idle phase per command
    if (launch) begin
      dh = dh_t'(n.prm[P_DRV]);
      n.ridx = '0;
      unique case (n.cmd)
        CM_WRITE, CM_WRDEL: begin
          // a last sector below the first still writes one sector
          secs = (n.prm[P_EOT] >= n.prm[P_REC])
               ? 9'(n.prm[P_EOT] - n.prm[P_REC]) + 9'h001 : 9'h001;
          bytes = 22'(secs * (SEC_BASE << n.prm[P_SIZE][2:0]));
          n.feed = bytes;
          n.left = bytes;
          n.wdel = n.cmd == CM_WRDEL;
          n.fmt = 1'b0;
          n.dsel = {dh.drive_select_high, dh.drive_select_low};
          n.head = dh.head_side_select;
          n.phase = PH_EXEC;
        end
        CM_FORMAT: begin
          bytes = 22'(n.prm[P_FSC]) << ID_SHIFT;
          n.feed = bytes;
          n.left = bytes;
          n.wdel = 1'b0;
          n.fmt = 1'b1;
          n.dsel = {dh.drive_select_high, dh.drive_select_low};
          n.head = dh.head_side_select;
          n.phase = PH_EXEC;
        end
        CM_RECAL, CM_SEEK: begin
          n.sreq.go = 1'b1;
          n.sreq.recal = n.cmd == CM_RECAL;
          n.sreq.drive = {dh.drive_select_high, dh.drive_select_low};
          n.sreq.start = q.pcyl[n.sreq.drive];
          n.sreq.target = n.prm[P_CYL];
          n.sreq.interval = q.spec1.step_interval;
          n.dsel = n.sreq.drive;
          n.head = dh.head_side_select;
          n.phase = PH_SEEK;
        end
        CM_SPEC: begin
          n.spec1 = spec1_t'(n.prm[0]);
          n.spec2 = spec2_t'(n.prm[1]);
          n.phase = PH_IDLE;
        end
        CM_SENSE: begin
          n.phase = PH_RES;
          if (q.irq) begin
            n.res[0] = ST0_SEEK_END | {6'h00, q.irq_drv};
            n.res[1] = q.pcyl[q.irq_drv];
            n.rlen = NR_SENSE;
            n.irq = 1'b0;
          end else begin
            n.res[0] = ST0_INVALID;
            n.rlen = NR_ONE;
          end
        end
        default: begin
          n.res[0] = ST0_INVALID;
          n.rlen = NR_ONE;
          n.phase = PH_RES;
        end
      endcase
    end
    // drive has taken every byte: build the result
    if (q.phase == PH_EXEC && q.left == '0) begin
      n.phase = PH_RES;
      n.ridx = '0;
      n.rlen = NR_RW;
      n.res = '0;
      n.res[0] = {5'h00, q.head, q.dsel};
      if (!q.fmt) begin
        n.res[3] = q.prm[P_CYL];
        n.res[4] = q.prm[P_HEAD];
        n.res[5] = q.prm[P_EOT];
        n.res[6] = q.prm[P_SIZE];
      end
    end
    // seek end comes last so it wins over any clear
    if (srsp.done) begin
      n.pcyl[q.sreq.drive] = srsp.cyl;
      n.irq = 1'b1;
      n.irq_drv = q.sreq.drive;
      n.phase = PH_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.phase <= PH_IDLE;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign int_o = q.irq;
  assign drive_sel_o = q.dsel;
  assign head_sel_o = q.head;
  assign disk_data_o = q.odat;
  assign disk_valid_o = q.ovld;
  assign disk_deleted_o = q.wdel;
  assign disk_format_o = q.fmt;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic [7:0] pcyl_irq;
  logic idle_op;
  logic last_prm;
  assign pcyl_irq = q.pcyl[q.irq_drv];
  assign idle_op = wr_data && q.phase == PH_IDLE;
  assign last_prm = wr_data && q.phase == PH_CMD
                 && q.pidx == q.plen - 4'h1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (q.ack |=> !q.ack)
    else $error("ack held longer than one cycle");
  rw_start_a: assert property (
    last_prm && q.cmd == CM_WRITE |=> q.phase == PH_EXEC && !q.wdel
      && q.left != '0) else $error("write data did not start");
  wrdel_mark_a: assert property (
    last_prm && q.cmd == CM_WRDEL |=> q.phase == PH_EXEC && q.wdel)
    else $error("deleted write lost its mark");
  rw_result_a: assert property (
    q.phase == PH_EXEC && q.left == '0 && !q.fmt |=> q.phase == PH_RES
      && q.rlen == NR_RW && q.res[5] == q.prm[P_EOT])
    else $error("write result wrong");
  recal_zero_a: assert property (
    srsp.done && q.sreq.recal |=> q.irq && q.phase == PH_IDLE
      && q.pcyl[q.sreq.drive] == 8'h00)
    else $error("recalibrate end wrong");
  seek_reach_a: assert property (
    srsp.done && !q.sreq.recal |=> q.pcyl[q.sreq.drive] == q.sreq.target)
    else $error("seek missed target");
  sense_first_a: assert property (
    idle_op && dat_i[7:0] == OP_SENSE && q.irq |=> q.rlen == NR_SENSE
      && q.res[0] == (ST0_SEEK_END | {6'h00, $past(q.irq_drv)}) && !q.irq)
    else $error("sense status wrong");
  sense_cyl_a: assert property (
    idle_op && dat_i[7:0] == OP_SENSE && q.irq
      |=> q.res[1] == $past(pcyl_irq))
    else $error("sense cylinder wrong");
  fmt_len_a: assert property (
    last_prm && q.cmd == CM_FORMAT |=> q.fmt
      && q.left == (22'(q.prm[P_FSC]) << ID_SHIFT))
    else $error("format byte count wrong");
  bad_op_a: assert property (
    idle_op && decode(dat_i[7:0]) == CM_INVALID |=> q.phase == PH_RES
      && q.res[0] == ST0_INVALID && q.rlen == NR_ONE)
    else $error("invalid opcode result wrong");

  write_done_c: cover property (q.phase == PH_EXEC && q.left == '0);
  seek_done_c: cover property (srsp.done && !q.sreq.recal);
  sense_irq_c: cover property (idle_op && dat_i[7:0] == OP_SENSE && q.irq);
  fifo_full_c: cover property (stall);

endmodule : fdc_cmd

// >>> sim/drive_model.sv
// behavioural floppy drive: head position, track-zero sensor, write sink
`timescale 1ns/1ps
module drive_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // head motion
  input wire logic step_i,
  input wire logic dir_i,
  output logic track0_o,
  // write stream
  input wire logic stall_i,
  output logic ready_o
);
  logic [7:0] cyl_q; // physical head cylinder
  logic step_q; // step level seen last cycle
  // a rising step edge moves the head; it cannot go below track 0
  always_ff @(posedge clk_i) begin
    step_q <= step_i;
    if (rst_i) begin
      cyl_q <= 8'h00;
    end else if (step_i && !step_q) begin
      cyl_q <= dir_i ? cyl_q + 8'h01 : cyl_q - {7'h00, |cyl_q};
    end
  end
  // sensor is true only over the outermost track
  assign track0_o = (cyl_q == 8'h00);
  // slow drive: refuses bytes while the bench stalls it
  assign ready_o = !stall_i;
endmodule : drive_model

// >>> sim/test_floppy_write_seek_command_set.sv
// self-checking bench for the floppy command sequencer
`timescale 1ns/1ps
module test_floppy_write_seek_command_set;
  import fdc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, stall = 0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, step_o, dir_o, track0_i, head_sel_o, int_o, disk_ready_i;
  logic disk_valid_o, disk_deleted_o, disk_format_o;
  logic [1:0] drive_sel_o;
  logic [7:0] disk_data_o, c, b;
  logic [31:0] rq[$]; // expected data-port reads
  logic [7:0] dq[$]; // expected bytes to the drive
  int error_cnt = 0, samples_checked = 0, seed = 32'hC78C, i;
  always #2 clk_i = ~clk_i;
  // short step unit keeps seeks to a few hundred cycles per step
  fdc_cmd #(.STEP_UNIT_CYC(4), .FIFO_DEPTH(8)) DUT (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .step_o(step_o), .dir_o(dir_o), .track0_i(track0_i),
    .drive_sel_o(drive_sel_o), .head_sel_o(head_sel_o), .int_o(int_o),
    .disk_data_o(disk_data_o), .disk_valid_o(disk_valid_o),
    .disk_ready_i(disk_ready_i), .disk_deleted_o(disk_deleted_o),
    .disk_format_o(disk_format_o));
  drive_model DRV (.clk_i(clk_i), .rst_i(rst_i), .step_i(step_o),
    .dir_i(dir_o), .track0_o(track0_i), .stall_i(stall),
    .ready_o(disk_ready_i));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // classic single cycle; waits for ack however long the slave takes
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic put(input logic [7:0] d);
    wb(1, ADR_DATA, d);
  endtask : put
  task automatic get(input logic [7:0] e);
    rq.push_back({24'h0, e});
    wb(0, ADR_DATA, 8'h00);
  endtask : get
  task automatic wait_int;
    repeat (4000) if (int_o !== 1'b1) @(posedge clk_i);
    chk({31'h0, int_o}, 1);
  endtask : wait_int
  // hand n stream bytes over, then let the drive empty the fifo
  task automatic stream(input int n, input logic [1:0] fl);
    for (i = 0; i < n; i++) begin
      b = 8'($random(seed));
      dq.push_back(b);
      put(b);
      if (i == 3)
        chk({30'h0, disk_format_o, disk_deleted_o}, {30'h0, fl});
    end
    repeat (3000) if (dq.size() != 0) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
  endtask : stream
  task automatic wr(input logic [4:0] o, input logic dl);
    b = 8'($random(seed));
    c = 8'($random(seed));
    put({b[7:6], 1'b0, o});
    put(8'h05);
    put(c);
    put(8'h01);
    put(8'h02);
    put(8'h00);
    put(8'h02);
    put(8'h1B);
    put(8'hFF);
    stream(128, {1'b0, dl});
    get(8'h05);
    get(8'h00);
    get(8'h00);
    get(c);
    get(8'h01);
    get(8'h02);
    get(8'h00);
  endtask : wr
  // ------------------------------------------------------------
  // monitor: oldest note against each result as it appears
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && !we_i && adr_i == ADR_DATA)
      chk(dat_o, rq.size() ? rq.pop_front() : 32'hX);
    if (ack_o === 1'b1 && !we_i && adr_i > ADR_STAT)
      chk(dat_o, 32'h0);
    if (disk_valid_o === 1'b1 && disk_ready_i === 1'b1)
      chk({24'h0, disk_data_o},
          dq.size() ? {24'h0, dq.pop_front()} : 32'hX);
  end
  // watchdog cuts a hang short
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    $display("BAD %0t timeout", $time);
    give_verdict;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    put(8'h00);
    wb(0, ADR_STAT, 8'h00);
    chk(dat_o, 32'h30);
    get(ST0_INVALID);
    put(OP_SENSE);
    get(ST0_INVALID);
    wb(0, 4'h8, 8'h00);
    put(OP_SPEC);
    put(8'hF0);
    put(8'h01);
    put(OP_SEEK);
    put(8'h05);
    put(8'h05);
    wait_int;
    wb(0, ADR_STAT, 8'h00);
    chk(dat_o, 32'h41);
    chk({29'h0, head_sel_o, drive_sel_o}, 32'h5);
    put(OP_SENSE);
    get(ST0_SEEK_END | 8'h01);
    get(8'h05);
    chk({31'h0, int_o}, 0);
    put(OP_RECAL);
    put(8'h02);
    wait_int;
    chk({31'h0, track0_i}, 1);
    put(OP_SENSE);
    get(ST0_SEEK_END | 8'h02);
    get(8'h00);
    // stalled drive lets the fifo fill until writes are held off
    fork
      begin
        stall <= 1;
        repeat (200) @(posedge clk_i);
        stall <= 0;
      end
    join_none
    wr(OP_WRITE, 0);
    wr(OP_WRDEL, 1);
    put(8'h4D);
    put(8'h00);
    put(8'h00);
    put(8'h02);
    put(8'h1B);
    put(8'hE5);
    stream(8, 2'b10);
    repeat (7) get(8'h00);
    give_verdict;
  end
endmodule : test_floppy_write_seek_command_set
